// *** hw/pixel_channel_status_word.sv ***
// Functional notes
// - Busy stays high while a command runs; new triggers then ignored.
// - Frame output flag high while transmitting; buffer untouched then.
// - Send ack toggles after accepted send; unchanged on invalid request.
// - Update ack toggles after buffer copy; unchanged on invalid request.
// - Command ack toggles per successful command; unchanged otherwise.
// - Reject flag set on bad command, held until next command executes.
// - Warning flag follows the channel warning condition.
// - Error flag follows the channel error condition.
// - Two-bit cycle tally increments each process cycle, wraps 3 to 0.
// - Host toggles run bit while idle; triggers during busy ignored, reject flag untouched.
// - Send or update after a command waits for frame output idle.
// - Command codes 0..9: nop fill clear copy move rotl rotr rev grad.
`timescale 1ns/1ps
`default_nettype none
module pixel_channel_status_word
    import pix_status_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         pd_strobe,
    input  wire host_req_t    host_req,
    input  wire logic [15:0]  cmd_code,
    input  wire logic         arg_ok,
    output logic              exec_start,
    output logic [15:0]       exec_code,
    input  wire logic         exec_done,
    output logic              frame_send_start,
    output logic              buffer_copy_start,
    input  wire logic         frame_active,
    input  wire logic         warning_cond,
    input  wire logic         error_cond,
    output logic [7:0]        status_entry_count,
    output status_word_t      status
);
    chan_state_t state_reg;
    logic [2:0]  req_new;
    logic        run_new;
    logic        send_new;
    logic        upd_new;
    logic        send_pend_reg;
    logic        upd_pend_reg;
    logic        busy_reg;
    logic        send_ack_reg;
    logic        upd_ack_reg;
    logic        cmd_ack_reg;
    logic        reject_reg;
    logic        warn_reg;
    logic        err_reg;
    logic [15:0] exec_code_reg;
    logic [1:0]  tally;
    logic        accept_cmd;
    logic        bad_cmd;
    logic        do_send;
    logic        do_update;

    // Request detection on host bit changes
    pix_req_edge #(.WIDTH(3)) u_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pd_strobe(pd_strobe),
        .req_bits (host_req),
        .req_new  (req_new)
    );

    assign run_new  = req_new[2];
    assign send_new = req_new[1];
    assign upd_new  = req_new[0];

    // Trigger while busy is simply dropped; busy_reg also covers the cycle
    // after the return to idle, when the host still reads busy high
    assign accept_cmd = run_new && (state_reg == ST_IDLE)
                        && !busy_reg;
    assign bad_cmd    = !cmd_valid(cmd_code) || !arg_ok;

    // Command state machine
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            exec_code_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept_cmd && !bad_cmd) begin
                        state_reg     <= ST_EXEC;
                        exec_code_reg <= cmd_code;
                    end
                end
                ST_EXEC: begin
                    if (exec_done) begin
                        state_reg <= ST_FOLLOW;
                    end
                end
                ST_FOLLOW: begin
                    // Hold busy until deferred send/update are issued
                    if (!send_pend_reg && !upd_pend_reg) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign exec_start = (state_reg == ST_IDLE) && accept_cmd && !bad_cmd;
    assign exec_code  = exec_code_reg;

    // Busy covers execution and the deferred follow-up
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != ST_IDLE) || exec_start;
        end
    end

    // Deferred frame jobs wait for frame output to go idle
    assign do_update = (state_reg == ST_FOLLOW) && upd_pend_reg
                       && !frame_active;
    assign do_send   = (state_reg == ST_FOLLOW) && !upd_pend_reg
                       && send_pend_reg && !frame_active;
    assign buffer_copy_start = do_update;
    assign frame_send_start  = do_send;

    // Send/update requests latched with an accepted command
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            send_pend_reg <= 1'b0;
            upd_pend_reg  <= 1'b0;
        end else if (exec_start) begin
            send_pend_reg <= send_new;
            upd_pend_reg  <= upd_new;
        end else begin
            if (do_send) begin
                send_pend_reg <= 1'b0;
            end
            if (do_update) begin
                upd_pend_reg <= 1'b0;
            end
        end
    end

    // Acknowledge toggles only for successful work
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            send_ack_reg <= 1'b0;
            upd_ack_reg  <= 1'b0;
            cmd_ack_reg  <= 1'b0;
        end else begin
            if (do_send) begin
                send_ack_reg <= !send_ack_reg;
            end
            if (do_update) begin
                upd_ack_reg <= !upd_ack_reg;
            end
            if (state_reg == ST_EXEC && exec_done) begin
                cmd_ack_reg <= !cmd_ack_reg;
            end
        end
    end

    // Reject is sticky until a command executes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reject_reg <= 1'b0;
        end else if (accept_cmd && bad_cmd) begin
            reject_reg <= 1'b1;
        end else if (exec_start) begin
            reject_reg <= 1'b0;
        end
    end

    // Condition flags follow the channel diagnostics
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            warn_reg <= 1'b0;
            err_reg  <= 1'b0;
        end else begin
            warn_reg <= warning_cond;
            err_reg  <= error_cond;
        end
    end

    pix_cycle_tally u_tally (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pd_strobe(pd_strobe),
        .tally    (tally)
    );

    // Status word assembly, all fields from flops except frame_output_active, taken straight from frame_active
    assign status_entry_count               = STATUS_ENTRY_COUNT;
    assign status.busy                      = busy_reg;
    assign status.frame_output_active       = frame_active;
    assign status.push_frame_ack_toggle     = send_ack_reg;
    assign status.buffer_refresh_ack_toggle = upd_ack_reg;
    assign status.op_done_ack_toggle        = cmd_ack_reg;
    assign status.op_refused_flag           = reject_reg;
    assign status.warning_flag              = warn_reg;
    assign status.error_flag                = err_reg;
    assign status.pd_cycle_tally            = tally;

    // A trigger seen while the host reads busy must never start the engine
    a_trigger_busy_ign: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        busy_reg |-> !exec_start)
        else $error("command started while busy");

    // Busy rises on the edge after a start
    a_busy_follows: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        exec_start |=> busy_reg)
        else $error("busy not raised after start");

    // Busy falls one cycle after the machine is back in idle
    a_busy_drop: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (busy_reg && state_reg == ST_IDLE) |=> !busy_reg)
        else $error("busy stuck after idle");

    // A later trigger must not overwrite the running command
    a_exec_code_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg != ST_IDLE) |=> $stable(exec_code))
        else $error("running command code changed");

    // No frame job may start while a frame is on the line
    a_no_send_active: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        frame_active |-> !frame_send_start && !buffer_copy_start)
        else $error("frame job during transmission");

    // Frame jobs only come as the follow-up of an executed command
    a_no_job_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg != ST_FOLLOW) |-> !frame_send_start && !buffer_copy_start)
        else $error("frame job outside command follow-up");

    // Send ack moves only when a frame send was issued
    a_send_ack_tog: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $changed(send_ack_reg) |-> $past(do_send))
        else $error("send ack toggled without send");

    // Every issued send flips the send ack
    a_send_ack_flip: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        do_send |=> send_ack_reg != $past(send_ack_reg))
        else $error("send ack did not toggle");

    // Every buffer copy flips the update ack
    a_upd_ack_tog: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        do_update |=> upd_ack_reg != $past(upd_ack_reg))
        else $error("update ack did not toggle");

    // Command ack moves only at the end of an execution
    a_cmd_ack_tog: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $changed(cmd_ack_reg) |-> $past(state_reg) == ST_EXEC)
        else $error("command ack toggled outside execution");

    // A bad command sets reject and leaves the command ack alone
    a_reject_sets: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept_cmd && bad_cmd) |=> reject_reg && $stable(cmd_ack_reg))
        else $error("reject not flagged");

    // Reject stays set until a command is started
    a_reject_held: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (reject_reg && !exec_start) |=> reject_reg)
        else $error("reject dropped without a command");

    // A started command clears reject
    a_reject_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        exec_start |=> !reject_reg)
        else $error("reject kept after command start");

    // A dropped trigger leaves the reject flag untouched
    a_busy_no_flag: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (run_new && busy_reg) |=> $stable(reject_reg))
        else $error("reject changed by trigger while busy");

    // Warning flag follows the condition one cycle late
    a_warn_follow: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rst_n |=> warn_reg == $past(warning_cond))
        else $error("warning flag lags wrong");

    // Error flag follows the condition one cycle late
    a_err_follow: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rst_n |=> err_reg == $past(error_cond))
        else $error("error flag lags wrong");

    // Tally advances by one per cycle, modulo four
    a_tally_step: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        pd_strobe |=> tally == $past(tally) + TALLY_STEP)
        else $error("tally did not advance");

    // Tally holds between process data cycles
    a_tally_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !pd_strobe |=> $stable(tally))
        else $error("tally moved without a cycle");

    // Reset leaves every flag except frame output active, every ack and the tally at zero
    a_reset_clear: assert property (
        @(posedge core_clk)
        !rst_n |=> !busy_reg && !send_ack_reg && !upd_ack_reg
                   && !cmd_ack_reg && !reject_reg && !warn_reg && !err_reg
                   && tally == TALLY_RESET)
        else $error("state not cleared by reset");
endmodule // pixel_channel_status_word
`default_nettype wire

// *** hw/pix_status_pkg.sv ***
package pix_status_pkg;

    // Subindex positions of the status word fields
    localparam int unsigned SUB_BUSY      = 1;
    localparam int unsigned SUB_TRANSMIT  = 2;
    localparam int unsigned SUB_SEND_ACK  = 3;
    localparam int unsigned SUB_UPD_ACK   = 4;
    localparam int unsigned SUB_CMD_ACK   = 5;
    localparam int unsigned SUB_REJECT    = 6;
    localparam int unsigned SUB_WARNING   = 11;
    localparam int unsigned SUB_ERROR     = 12;
    localparam int unsigned SUB_TALLY_LO  = 15;
    localparam int unsigned STATUS_W      = 17;

    localparam logic [7:0] STATUS_ENTRY_COUNT = 8'h0f;
    localparam logic [1:0] TALLY_RESET        = 2'h0;
    localparam logic [1:0] TALLY_MAX          = 2'h3;
    localparam logic [1:0] TALLY_STEP         = 2'h1;

    // Command codes
    typedef enum logic [15:0] {
        CMD_NOP        = 16'h0000,
        CMD_FILL       = 16'h0001,
        CMD_CLEAR      = 16'h0002,
        CMD_COPY       = 16'h0003,
        CMD_MOVE       = 16'h0004,
        CMD_ROT_LEFT   = 16'h0005,
        CMD_ROT_RIGHT  = 16'h0006,
        CMD_REVERSE    = 16'h0007,
        CMD_GRAD_1     = 16'h0008,
        CMD_GRAD_2     = 16'h0009
    } cmd_code_t;

    localparam logic [15:0] CMD_LAST = 16'h0009;

    // Host request bits sampled once per process data cycle
    typedef struct packed {
        logic run_toggle;
        logic send_req;
        logic update_req;
    } host_req_t;

    // Channel status word as read by the host
    typedef struct packed {
        logic       busy;
        logic       frame_output_active;
        logic       push_frame_ack_toggle;
        logic       buffer_refresh_ack_toggle;
        logic       op_done_ack_toggle;
        logic       op_refused_flag;
        logic       warning_flag;
        logic       error_flag;
        logic [1:0] pd_cycle_tally;
    } status_word_t;

    // Channel command states: idle, engine executing, deferred send/update follow-up
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC   = 2'b01,
        ST_FOLLOW = 2'b11
    } chan_state_t;

    function automatic logic cmd_valid(input logic [15:0] code);
        return code <= CMD_LAST;
    endfunction

endpackage

// *** hw/pix_req_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
module pix_req_edge
    import pix_status_pkg::*;
#(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             pd_strobe,
    input  wire logic [WIDTH-1:0] req_bits,
    output logic      [WIDTH-1:0] req_new
);
    logic [WIDTH-1:0] last_reg;

    // Remember host bits from the previous process data cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_reg <= '0;
        end else if (pd_strobe) begin
            last_reg <= req_bits;
        end
    end

    // Any change seen at a cycle counts as exactly one request
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign req_new[g] = pd_strobe && (req_bits[g] != last_reg[g]);
        end
    endgenerate
endmodule // pix_req_edge
`default_nettype wire

// *** hw/pix_cycle_tally.sv ***
`timescale 1ns/1ps
`default_nettype none
module pix_cycle_tally
    import pix_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       pd_strobe,
    output logic      [1:0] tally
);
    logic [1:0] tally_reg;

    // Two-bit count wraps naturally from the maximum back to zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tally_reg <= TALLY_RESET;
        end else if (pd_strobe) begin
            tally_reg <= (tally_reg == TALLY_MAX) ? TALLY_RESET
                                                  : tally_reg + TALLY_STEP;
        end
    end

    assign tally = tally_reg;
endmodule // pix_cycle_tally
`default_nettype wire

// *** dv/pix_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pix_engine_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic hold,
    input  wire logic exec_start,
    input  wire logic frame_send_start,
    output logic      exec_done,
    output logic      frame_active
);
    logic [3:0] run_cnt;
    logic [3:0] tx_cnt;

    // Job timer; slow mode lets a trigger land while busy
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            run_cnt <= 4'h0;
        else if (exec_start)
            run_cnt <= slow ? 4'hc : 4'h3;
        else if (run_cnt != 4'h0)
            run_cnt <= run_cnt - 4'h1;
    end
    assign exec_done = (run_cnt == 4'h1);

    // Fixed frame span; hold keeps the LED line busy
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            tx_cnt <= 4'h0;
        else if (frame_send_start)
            tx_cnt <= 4'h8;
        else if (tx_cnt != 4'h0)
            tx_cnt <= tx_cnt - 4'h1;
    end
    assign frame_active = hold | (tx_cnt != 4'h0);
endmodule // pix_engine_model
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module tb;
    import pix_status_pkg::*;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         pd_strobe = 1'b0;
    host_req_t    host_req = '0;
    logic [15:0]  cmd_code = 16'h0000;
    logic         arg_ok = 1'b1;
    logic         warning_cond = 1'b0;
    logic         error_cond = 1'b0;
    logic         slow = 1'b0;
    logic         hold = 1'b0;
    logic         exec_start, exec_done, frame_send_start;
    logic         buffer_copy_start, frame_active;
    logic [15:0]  exec_code;
    logic [7:0]   status_entry_count;
    status_word_t status;
    status_word_t s0;
    logic [1:0]   tally_exp = 2'h0;
    int           err_count = 0;
    int           checked = 0;
    int           cyc = 0;

    pixel_channel_status_word pixel_channel_status_word_inst (
        .core_clk(core_clk), .rst_n(rst_n), .pd_strobe(pd_strobe),
        .host_req(host_req), .cmd_code(cmd_code), .arg_ok(arg_ok),
        .exec_start(exec_start), .exec_code(exec_code),
        .exec_done(exec_done), .frame_send_start(frame_send_start),
        .buffer_copy_start(buffer_copy_start),
        .frame_active(frame_active), .warning_cond(warning_cond),
        .error_cond(error_cond),
        .status_entry_count(status_entry_count), .status(status));
    pix_engine_model pix_engine_model_inst (
        .core_clk(core_clk), .rst_n(rst_n), .slow(slow), .hold(hold),
        .exec_start(exec_start), .frame_send_start(frame_send_start),
        .exec_done(exec_done), .frame_active(frame_active));

    always #5 core_clk = ~core_clk;

    // Buffer touched mid-frame, or hang
    always @(posedge core_clk) begin
        cyc++;
        if (rst_n && frame_active && (frame_send_start || buffer_copy_start))
            `CHK(1'b1, 1'b0)
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One process data cycle; request bits toggle as levels
    task automatic pd_cycle(input logic rt, input logic sd,
                            input logic up, input logic [15:0] code,
                            input logic ok);
        @(posedge core_clk);
        pd_strobe <= 1'b1;
        host_req <= host_req ^ {rt, sd, up};
        cmd_code <= code;
        arg_ok <= ok;
        warning_cond <= 1'($urandom);
        error_cond <= 1'($urandom);
        @(posedge core_clk);
        pd_strobe <= 1'b0;
        tally_exp = tally_exp + 2'h1;
        #1;
        `CHK(status.pd_cycle_tally, tally_exp)
        `CHK(status.warning_flag, warning_cond)
        `CHK(status.error_flag, error_cond)
    endtask

    // Bounded wait for the channel to go idle
    task automatic wait_idle();
        for (int n = 0; n < 60 && status.busy !== 1'b0; n++)
            @(posedge core_clk) #1;
    endtask

    // Outcome of a command as the rules define it
    function automatic logic expect_good(input logic [15:0] code,
                                         input logic ok);
        return ok && (code <= CMD_LAST);
    endfunction

    task automatic run_cmd(input logic [15:0] code, input logic ok,
                           input logic sd, input logic up);
        logic good;
        logic cmd_a;
        logic send_a;
        logic upd_a;
        s0 = status;
        good = expect_good(code, ok);
        cmd_a = s0.op_done_ack_toggle ^ good;
        send_a = s0.push_frame_ack_toggle ^ (good & sd);
        upd_a = s0.buffer_refresh_ack_toggle ^ (good & up);
        pd_cycle(1'b1, sd, up, code, ok);
        `CHK(status.busy, good)
        if (good)
            `CHK(exec_code, code)
        wait_idle();
        `CHK(status.op_done_ack_toggle, cmd_a)
        `CHK(status.push_frame_ack_toggle, send_a)
        `CHK(status.buffer_refresh_ack_toggle, upd_a)
        `CHK(status.op_refused_flag, !good)
    endtask

    initial begin
        void'($urandom(32'h5daa));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        `CHK(status, status_word_t'('0))
        `CHK(status_entry_count, 8'h0f)
        for (int c = 0; c < 10; c++)
            run_cmd(16'(c), 1'b1, c[0], c[1]);
        run_cmd(16'h000a, 1'b1, 1'b1, 1'b1);
        pd_cycle(1'b0, 1'b1, 1'b1, 16'h0001, 1'b1);
        `CHK(status.op_refused_flag, 1'b1)
        run_cmd(16'h0003, 1'b0, 1'b0, 1'b1);
        run_cmd(16'h0002, 1'b1, 1'b0, 1'b0);
        // Second trigger while busy must be dropped
        slow <= 1'b1;
        s0 = status;
        pd_cycle(1'b1, 1'b0, 1'b0, 16'h0001, 1'b1);
        pd_cycle(1'b1, 1'b0, 1'b0, 16'h0004, 1'b1);
        `CHK(exec_code, 16'h0001)
        wait_idle();
        `CHK(status.op_done_ack_toggle, ~s0.op_done_ack_toggle)
        `CHK(status.op_refused_flag, 1'b0)
        slow <= 1'b0;
        // Send held back while a frame is still out
        hold <= 1'b1;
        s0 = status;
        pd_cycle(1'b1, 1'b1, 1'b0, 16'h0007, 1'b1);
        repeat (30) @(posedge core_clk);
        `CHK(status.busy, 1'b1)
        `CHK(status.push_frame_ack_toggle, s0.push_frame_ack_toggle)
        hold <= 1'b0;
        wait_idle();
        `CHK(status.push_frame_ack_toggle, ~s0.push_frame_ack_toggle)
        repeat (30)
            run_cmd(16'($urandom_range(0, 12)), 1'($urandom_range(0, 3) != 0),
                    1'($urandom), 1'($urandom));
        // Mid-run reset must return every flag, ack and the tally to zero
        @(posedge core_clk);
        rst_n <= 1'b0;
        host_req <= '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        tally_exp = 2'h0;
        #1;
        `CHK(status, status_word_t'('0))
        run_cmd(16'h0001, 1'b1, 1'b1, 1'b1);
        summarize();
    end
endmodule // tb
`default_nettype wire
